// ### ssed_pkg.sv
package ssed_pkg;

  localparam int DATA_W         = 16;
  localparam int ADDR_W         = 16;
  localparam int BIT_CNT_W      = $clog2(DATA_W + 1);
  localparam int FIFO_DEPTH_DEF = 8;

  localparam logic [ADDR_W-1:0] ADDR_TB  = 16'hf0b0;
  localparam logic [ADDR_W-1:0] ADDR_RB  = 16'hf0b2;
  localparam logic [ADDR_W-1:0] ADDR_BR  = 16'hf0b4;
  localparam logic [ADDR_W-1:0] ADDR_TIC = 16'hff72;
  localparam logic [ADDR_W-1:0] ADDR_RIC = 16'hff74;
  localparam logic [ADDR_W-1:0] ADDR_EIC = 16'hff76;
  localparam logic [ADDR_W-1:0] ADDR_CON = 16'hffb2;

  // Fault index: enables sit at CON_EN_LSB+i, flags at CON_FLAG_LSB+i.
  localparam int NUM_FAULT    = 4;
  localparam int F_UND        = 0;
  localparam int F_OVR        = 1;
  localparam int F_PH         = 2;
  localparam int F_RATE       = 3;
  localparam int CON_EN_LSB   = 0;
  localparam int CON_ARE      = 4;
  localparam int CON_MS       = 5;
  localparam int CON_TXW      = 6;
  localparam int CON_BUSY     = 7;
  localparam int CON_FLAG_LSB = 8;
  localparam int CON_EN       = 15;

  localparam logic [DATA_W-1:0] CON_WR_MASK = 16'h803f;
  localparam logic [DATA_W-1:0] CON_RST     = 16'h0000;
  localparam logic [DATA_W-1:0] BR_RST      = 16'h0000;
  localparam logic [DATA_W-1:0] IC_RST      = 16'h0000;
  localparam logic [DATA_W-1:0] ZERO_WORD   = 16'h0000;

  // Pin sample slots in the synchroniser vector.
  localparam int SYN_W    = 3;
  localparam int SYN_SCLK = 2;
  localparam int SYN_MOSI = 1;
  localparam int SYN_MISO = 0;

  localparam int PHASE_PRE_CYC  = 1;
  localparam int PHASE_POST_CYC = 2;
  localparam int PH_CNT_W       = 2;
  localparam int RATE_W         = DATA_W + 2;
  localparam int RATE_SHIFT     = 1;

  typedef enum logic {XF_IDLE, XF_RUN} ssed_xfer_t;

endpackage

// ### ssed_stream_if.sv
`timescale 1ns/1ps
interface ssed_stream_if #(parameter int W = 16);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### ssed_fifo.sv
`timescale 1ns/1ps
module ssed_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  input  wire logic   core_clk,
  input  wire logic   rst_b,
  ssed_stream_if.snk  push,
  ssed_stream_if.src  pop
);
  import ssed_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [CW-1:0] cnt_ff;

  wire do_push = push.valid && push.ready;
  wire do_pop  = pop.valid && pop.ready;
  wire [PW-1:0] wr_ptr_inc = (wr_ptr_ff == PW'(DEPTH - 1)) ? '0
                           : wr_ptr_ff + PW'(1);
  wire [PW-1:0] rd_ptr_inc = (rd_ptr_ff == PW'(DEPTH - 1)) ? '0
                           : rd_ptr_ff + PW'(1);

  // Full and empty come from the count, so a simultaneous push and pop
  // on a full FIFO is refused on the push side rather than overwriting.
  assign push.ready = (cnt_ff != CW'(DEPTH));
  assign pop.valid  = (cnt_ff != '0);
  assign pop.data   = mem[rd_ptr_ff];

  always_ff @(posedge core_clk)
  begin
    if (do_push)
    begin
      mem[wr_ptr_ff] <= push.data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr_ff <= wr_ptr_inc;
      if (do_pop)
        rd_ptr_ff <= rd_ptr_inc;
      cnt_ff <= cnt_ff + CW'(do_push) - CW'(do_pop);
    end
  end

endmodule

// ### ssed_top.sv
// How it works
// - Receive and phase faults in both roles; underrun and rate only as slave.
// - Each fault sets its flag and, if enabled, raises the error request.
// - Flags stay set until software writes them clear.
// - Error request persists while any enabled flag stays set.
// - New frame complete while receive buffer unread flags overrun.
// - On overrun the receive buffer still takes the new frame.
// - Data change from one cycle before to two after latch flags phase.
// - Slave clock faster than double or slower than half flags rate.
// - Rate fault with auto reset enabled reinitialises the channel.
// - Slave start without fresh transmit buffer flags underrun.
// - Slave start without fresh buffer shifts out old shift contents.
// - Three request outputs: transmit, receive and error.
// - Enabled: rate register reads live count, writes refused.
`timescale 1ns/1ps
module ssed_top #(
  parameter int FIFO_DEPTH = ssed_pkg::FIFO_DEPTH_DEF
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst_b,
  input  wire logic [ssed_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [ssed_pkg::DATA_W-1:0] reg_wdata,
  output logic      [ssed_pkg::DATA_W-1:0] reg_rdata,
  output logic                             tx_buf_ready,
  input  wire logic                        sclk_pin,
  output logic                             sclk_drive,
  input  wire logic                        master_in_slave_out_line_pin,
  output logic                             master_in_slave_out_line_drive,
  input  wire logic                        master_out_slave_in_line_pin,
  output logic                             master_out_slave_in_line_drive,
  output logic                             tx_request,
  output logic                             rx_request,
  output logic                             error_request_line
);
  import ssed_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. Only the second stage and later are read.

  logic [SYN_W-1:0] sync1_ff;
  logic [SYN_W-1:0] sync2_ff;
  logic [SYN_W-1:0] pin_d_ff;
  wire  [SYN_W-1:0] pins = {sclk_pin, master_out_slave_in_line_pin,
                            master_in_slave_out_line_pin};

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      pin_d_ff <= '0;
    end
    else
    begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
      pin_d_ff <= sync2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register decode and state.

  logic [DATA_W-1:0]    con_ff;
  logic [NUM_FAULT-1:0] flags_ff;
  logic [NUM_FAULT-1:0] nxt_flags;
  logic [NUM_FAULT-1:0] flag_set;
  logic [DATA_W-1:0]    reload_ff;
  logic [DATA_W-1:0]    timer_ff;
  logic [DATA_W-1:0]    ic_ff [3];
  logic [DATA_W-1:0]    rx_buf_ff;
  logic [DATA_W-1:0]    shift_ff;
  logic [DATA_W-1:0]    rdata_ff;
  logic                 rx_unread_ff;
  logic                 tx_written_ff;
  logic                 shift_loaded_ff;
  logic                 sclk_drv_ff;
  logic                 din_cap_ff;
  logic                 ph_ref_ff;
  logic [PH_CNT_W-1:0]  ph_win_ff;
  logic [RATE_W-1:0]    gap_ff;
  logic [BIT_CNT_W-1:0] bit_cnt_ff;
  logic                 tx_req_ff;
  logic                 rx_req_ff;
  ssed_xfer_t           xfer_ff;
  ssed_xfer_t           nxt_xfer;

  wire wr_tb  = reg_wr && (reg_addr == ADDR_TB);
  wire wr_br  = reg_wr && (reg_addr == ADDR_BR);
  wire wr_con = reg_wr && (reg_addr == ADDR_CON);
  wire rd_rb  = reg_rd && (reg_addr == ADDR_RB);
  wire [2:0] wr_ic = {reg_wr && (reg_addr == ADDR_EIC),
                      reg_wr && (reg_addr == ADDR_RIC),
                      reg_wr && (reg_addr == ADDR_TIC)};

  wire ch_en  = con_ff[CON_EN];
  wire master = con_ff[CON_MS];
  wire are_en = con_ff[CON_ARE];
  wire [NUM_FAULT-1:0] fault_en = con_ff[CON_EN_LSB +: NUM_FAULT];
  wire running = (xfer_ff == XF_RUN);

  ssed_stream_if #(.W(DATA_W)) tx_push ();
  ssed_stream_if #(.W(DATA_W)) tx_pop ();

  ssed_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .push     (tx_push),
    .pop      (tx_pop)
  );

  assign tx_push.valid = wr_tb;
  assign tx_push.data  = reg_wdata;
  assign tx_buf_ready  = tx_push.ready;
  assign tx_pop.ready  = ch_en && !running && !shift_loaded_ff;
  wire   load          = tx_pop.valid && tx_pop.ready;

  ////////////////////////////////////////////////////////////////////////////
  // Clock edges, framing and fault detection.

  wire expire  = ch_en && (timer_ff == ZERO_WORD);
  wire m_tick  = master && running && expire;
  wire s_rise  = !master && ch_en && sync2_ff[SYN_SCLK] && !pin_d_ff[SYN_SCLK];
  wire s_fall  = !master && ch_en && !sync2_ff[SYN_SCLK] && pin_d_ff[SYN_SCLK];
  wire s_start = s_rise && !running;
  wire latch   = master ? (m_tick && !sclk_drv_ff) : (s_rise && (running || s_start));
  wire shift   = master ? (m_tick && sclk_drv_ff) : (s_fall && running);
  wire m_end   = m_tick && sclk_drv_ff && (bit_cnt_ff == BIT_CNT_W'(DATA_W));
  wire done    = latch && (bit_cnt_ff == BIT_CNT_W'(DATA_W - 1));
  wire din     = master ? sync2_ff[SYN_MISO] : sync2_ff[SYN_MOSI];
  wire din_d   = master ? pin_d_ff[SYN_MISO] : pin_d_ff[SYN_MOSI];
  wire [DATA_W-1:0] rx_word = {shift_ff[DATA_W-2:0], din};

  wire [RATE_W-1:0] half_per = RATE_W'(reload_ff) + RATE_W'(1);
  wire s_edge     = (s_rise || s_fall) && running;
  wire rate_fast  = s_edge && (gap_ff < (half_per >> RATE_SHIFT));
  wire rate_slow  = !master && running && (gap_ff > (half_per << RATE_SHIFT));
  wire rate_fault = rate_fast || rate_slow;
  wire auto_rst   = rate_fault && are_en;
  wire underrun   = s_start && !shift_loaded_ff && !tx_written_ff;
  wire phase      = (latch && (din != din_d))
                 || ((ph_win_ff != '0) && (din != ph_ref_ff));

  assign flag_set[F_UND]  = underrun;
  assign flag_set[F_OVR]  = done && rx_unread_ff && !rd_rb;
  assign flag_set[F_PH]   = phase;
  assign flag_set[F_RATE] = rate_fault;

  // A hardware set beats a software clear written in the same cycle.
  genvar g;
  generate
    for (g = 0; g < NUM_FAULT; g++)
    begin : g_flag
      assign nxt_flags[g] = flag_set[g]
                          | (wr_con ? reg_wdata[CON_FLAG_LSB + g]
                                    : flags_ff[g]);
    end
  endgenerate

  always_comb
  begin
    nxt_xfer = xfer_ff;
    unique case (xfer_ff)
      XF_IDLE:
        if ((master && shift_loaded_ff) || s_start)
          nxt_xfer = XF_RUN;
      XF_RUN:
        if (auto_rst || !ch_en || m_end || (!master && done))
          nxt_xfer = XF_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, status and buffers.

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      con_ff    <= CON_RST;
      flags_ff  <= '0;
      reload_ff <= BR_RST;
      ic_ff     <= '{IC_RST, IC_RST, IC_RST};
    end
    else
    begin
      if (wr_con)
        con_ff <= reg_wdata & CON_WR_MASK;
      flags_ff <= nxt_flags;
      if (wr_br && !ch_en)
        reload_ff <= reg_wdata;
      for (int i = 0; i < 3; i++)
        if (wr_ic[i])
          ic_ff[i] <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rx_buf_ff     <= ZERO_WORD;
      rx_unread_ff  <= 1'b0;
      tx_written_ff <= 1'b0;
    end
    else
    begin
      if (done)
        rx_buf_ff <= rx_word;
      rx_unread_ff  <= done || (rx_unread_ff && !rd_rb);
      tx_written_ff <= (wr_tb && tx_push.ready) || (tx_written_ff && !load);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud timer, shift engine and fault timing.

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      timer_ff        <= BR_RST;
      xfer_ff         <= XF_IDLE;
      bit_cnt_ff      <= '0;
      sclk_drv_ff     <= 1'b0;
      shift_ff        <= ZERO_WORD;
      shift_loaded_ff <= 1'b0;
      din_cap_ff      <= 1'b0;
    end
    else
    begin
      timer_ff <= (!ch_en || expire || auto_rst) ? reload_ff
                                                 : timer_ff - 16'h0001;
      xfer_ff  <= nxt_xfer;
      if (nxt_xfer == XF_IDLE)
        bit_cnt_ff <= '0;
      else if (latch)
        bit_cnt_ff <= bit_cnt_ff + BIT_CNT_W'(1);
      sclk_drv_ff <= (m_tick && !auto_rst) ? !sclk_drv_ff
                   : (running ? sclk_drv_ff : 1'b0);
      if (latch)
        din_cap_ff <= din;
      // Without a fresh load the slave simply keeps shifting the old word.
      // A master holds its last bit until the closing fall, so the far
      // slave never sees its data line move on the edge that samples it.
      if (load)
        shift_ff <= tx_pop.data;
      else if (done && !master)
        shift_ff <= rx_word;
      else if (m_end)
        shift_ff <= rx_buf_ff;
      else if (shift)
        shift_ff <= {shift_ff[DATA_W-2:0], din_cap_ff};
      shift_loaded_ff <= load || (shift_loaded_ff && !done && !auto_rst);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ph_ref_ff <= 1'b0;
      ph_win_ff <= '0;
      gap_ff    <= '0;
    end
    else
    begin
      if (latch)
      begin
        ph_ref_ff <= din_d;
        ph_win_ff <= PH_CNT_W'(PHASE_POST_CYC);
      end
      else if (ph_win_ff != '0)
        ph_win_ff <= ph_win_ff - PH_CNT_W'(1);
      // Gap counts cycles since the last slave clock edge of this frame.
      if (!running || s_start || s_edge || rate_slow)
        gap_ff <= RATE_W'(1);
      else if (gap_ff != '1)
        gap_ff <= gap_ff + RATE_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port and requests.

  wire [DATA_W-1:0] con_view = con_ff
                             | (DATA_W'(flags_ff) << CON_FLAG_LSB)
                             | (DATA_W'(running) << CON_BUSY)
                             | (DATA_W'(tx_written_ff) << CON_TXW);
  wire [DATA_W-1:0] br_view  = ch_en ? timer_ff : reload_ff;
  wire [DATA_W-1:0] rd_mux   =
      (reg_addr == ADDR_RB)  ? rx_buf_ff :
      (reg_addr == ADDR_BR)  ? br_view   :
      (reg_addr == ADDR_CON) ? con_view  :
      (reg_addr == ADDR_TIC) ? ic_ff[0]  :
      (reg_addr == ADDR_RIC) ? ic_ff[1]  :
      (reg_addr == ADDR_EIC) ? ic_ff[2]  : ZERO_WORD;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rdata_ff  <= ZERO_WORD;
      tx_req_ff <= 1'b0;
      rx_req_ff <= 1'b0;
    end
    else
    begin
      if (reg_rd)
        rdata_ff <= rd_mux;
      tx_req_ff <= load;
      rx_req_ff <= done;
    end
  end

  assign reg_rdata          = rdata_ff;
  assign tx_request         = tx_req_ff;
  assign rx_request         = rx_req_ff;
  assign error_request_line = |(flags_ff & fault_en);
  assign sclk_drive         = sclk_drv_ff;
  assign master_in_slave_out_line_drive = shift_ff[DATA_W-1];
  assign master_out_slave_in_line_drive = shift_ff[DATA_W-1];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_latch_then_change;
    (latch && !wr_con) ##1 ((din != ph_ref_ff) && !wr_con);
  endsequence

  a_flag_sticky: assert property (
    (|($past(flags_ff) & ~flags_ff)) |-> $past(wr_con))
    else $error("fault flag cleared without a control write");
  a_err_request: assert property (
    (|(flag_set & fault_en) && !wr_con) |=> error_request_line)
    else $error("enabled fault did not raise the error request");
  a_err_persist: assert property (
    (error_request_line && !wr_con) |=> error_request_line)
    else $error("error request dropped while flags held");
  a_overrun_set: assert property (
    (done && rx_unread_ff && !rd_rb && !wr_con) |=> flags_ff[F_OVR])
    else $error("overrun not flagged");
  a_rx_overwrite: assert property (
    done |=> (rx_buf_ff == $past(rx_word)))
    else $error("receive buffer not overwritten by new frame");
  a_phase_window: assert property (
    s_latch_then_change |=> flags_ff[F_PH])
    else $error("phase change after latch not flagged");
  a_slave_only: assert property (
    master |-> !(underrun || rate_fault))
    else $error("slave-only fault raised in master role");
  a_underrun_set: assert property (
    (underrun && !wr_con) |=> flags_ff[F_UND] ##0 running)
    else $error("underrun not flagged at slave start");
  a_rate_reset: assert property (
    auto_rst |=> (xfer_ff == XF_IDLE) && !shift_loaded_ff)
    else $error("rate fault with auto reset did not reinitialise");
  a_br_locked: assert property (
    (ch_en && wr_br) |=> (reload_ff == $past(reload_ff)))
    else $error("rate reload changed while channel enabled");

endmodule

// ### ssed_partner.sv
`timescale 1ns/1ps
module ssed_partner (
  output logic      sclk_o,
  output logic      mosi_o,
  output logic      miso_o,
  input  wire logic sclk_i,
  input  wire logic mosi_i,
  input  wire logic miso_i
);
  logic [15:0] s_tx;
  logic [15:0] s_rx;
  int          s_cnt = 16;

  initial
  begin
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    miso_o = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Far master: clock idles low, data set half a period before each rise.
  task automatic xfer(input logic [15:0] tx, input int half, input int nb,
                      input int slow, input bit gl, output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = 15; i > 15 - nb; i--)
    begin
      mosi_o = tx[i];
      #(half);
      sclk_o = 1'b1;
      rx[i] = miso_i;
      if (gl && i == 8)
      begin
        #2;
        mosi_o = ~mosi_o;
      end
      #((i == 16 - nb) ? slow : half);
      sclk_o = 1'b0;
    end
    // A released line shows the inverse, so a stale level never matches.
    mosi_o = ~mosi_o;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Far slave: first bit out when armed, next bit after each falling edge.
  task automatic arm(input logic [15:0] wd);
    s_tx = wd;
    s_cnt = 0;
    miso_o = wd[15];
  endtask

  always @(posedge sclk_i)
    if (s_cnt < 16)
    begin
      s_rx = {s_rx[14:0], mosi_i};
      s_cnt = s_cnt + 1;
    end

  always @(negedge sclk_i)
    miso_o = (s_cnt < 16) ? s_tx[15 - s_cnt] : ~miso_o;
endmodule

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  import ssed_pkg::*;
  logic              core_clk;
  logic              rst_b;
  logic [ADDR_W-1:0] reg_addr;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic              tx_buf_ready;
  logic              sclk_pin;
  logic              sclk_drive;
  logic              miso_pin;
  logic              miso_drive;
  logic              mosi_pin;
  logic              mosi_drive;
  logic              tx_request;
  logic              rx_request;
  logic              error_request_line;
  logic [31:0]       seed = 32'h0000_0014;
  logic [15:0]       w;
  logic [15:0]       p;
  logic [15:0]       r;
  logic [15:0]       q[$];
  int                mismatches;
  int                n_tests;
  int                rx_cnt;
  int                tx_cnt;
  int                cyc;
  int                c;

  ssed_top #(.FIFO_DEPTH(8)) i_dut (
    .core_clk                       (core_clk),
    .rst_b                          (rst_b),
    .reg_addr                       (reg_addr),
    .reg_wr                         (reg_wr),
    .reg_rd                         (reg_rd),
    .reg_wdata                      (reg_wdata),
    .reg_rdata                      (reg_rdata),
    .tx_buf_ready                   (tx_buf_ready),
    .sclk_pin                       (sclk_pin),
    .sclk_drive                     (sclk_drive),
    .master_in_slave_out_line_pin   (miso_pin),
    .master_in_slave_out_line_drive (miso_drive),
    .master_out_slave_in_line_pin   (mosi_pin),
    .master_out_slave_in_line_drive (mosi_drive),
    .tx_request                     (tx_request),
    .rx_request                     (rx_request),
    .error_request_line             (error_request_line)
  );

  ssed_partner i_partner (
    .sclk_o (sclk_pin),
    .mosi_o (mosi_pin),
    .miso_o (miso_pin),
    .sclk_i (sclk_drive),
    .mosi_i (mosi_drive),
    .miso_i (miso_drive)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    rx_cnt = rx_cnt + (rx_request === 1'b1);
    tx_cnt = tx_cnt + (tx_request === 1'b1);
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  function automatic logic [15:0] exp_con(input logic [3:0] fl,
                                         input logic [5:0] ctl);
    return {1'b1, 3'h0, fl, 2'b00, ctl};
  endfunction

  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    #1;
    d = reg_rdata;
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [15:0] e,
                       input string what);
    logic [15:0] d;
    rd(a, d);
    chk(what, e, d);
  endtask

  // The odd delay keeps the link clock unrelated in phase to core_clk.
  task automatic frame(input logic [15:0] tx, input int nb, input int slow,
                       input bit gl, output logic [15:0] rx);
    #3.7;
    i_partner.xfer(tx, 40, nb, slow, gl, rx);
    repeat (8) @(posedge core_clk);
  endtask

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_b = 1'b0;
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    rdchk(ADDR_CON, CON_RST, "con reset");
    rdchk(16'hf0b6, ZERO_WORD, "unmapped");
    for (int k = 0; k < 3; k++)
    begin
      w = xs();
      rdchk(ADDR_TIC + 16'(2 * k), IC_RST, "ic reset");
      wr(ADDR_TIC + 16'(2 * k), w);
      rdchk(ADDR_TIC + 16'(2 * k), w, "ic store");
    end
    wr(ADDR_BR, 16'h0007);
    rdchk(ADDR_BR, 16'h0007, "br reload");
    // Fill the transmit queue while disabled; the ninth word is refused.
    for (int k = 0; k < 9; k++)
    begin
      w = xs();
      #1;
      chk("tb ready", 16'(k < 8), 16'(tx_buf_ready));
      if (k < 8)
        q.push_back(w);
      wr(ADDR_TB, w);
    end
    wr(ADDR_CON, 16'h8000);
    wr(ADDR_BR, 16'h0033);
    for (int k = 0; k < 8; k++)
    begin
      w = xs();
      frame(w, 16, 40, 0, r);
      chk("miso word", q.pop_front(), r);
      rdchk(ADDR_RB, w, "rb word");
    end
    chk("rx pulses", 16'h0008, 16'(rx_cnt));
    chk("tx pulses", 16'h0008, 16'(tx_cnt));
    chk("tb ready", 16'h0001, 16'(tx_buf_ready));
    p = w;
    wr(ADDR_CON, 16'h8002);
    frame(xs(), 16, 40, 0, r);
    chk("old shift", p, r);
    chk("err gated", 16'h0000, 16'(error_request_line));
    rdchk(ADDR_CON, exp_con(4'h1, 6'h02), "underrun");
    w = xs();
    frame(w, 16, 40, 0, r);
    chk("err ovr", 16'h0001, 16'(error_request_line));
    rdchk(ADDR_CON, exp_con(4'h3, 6'h02), "overrun");
    repeat (40) @(posedge core_clk);
    rdchk(ADDR_CON, exp_con(4'h3, 6'h02), "sticky");
    chk("err held", 16'h0001, 16'(error_request_line));
    rdchk(ADDR_RB, w, "rb newest");
    wr(ADDR_CON, 16'h8102);
    #1;
    chk("err clear", 16'h0000, 16'(error_request_line));
    rdchk(ADDR_CON, exp_con(4'h1, 6'h02), "clear one");
    wr(ADDR_CON, 16'h8004);
    wr(ADDR_TB, 16'hffff);
    frame(xs(), 16, 40, 1, r);
    chk("idle ones", 16'hffff, r);
    rdchk(ADDR_CON, exp_con(4'h4, 6'h04), "phase");
    chk("err phase", 16'h0001, 16'(error_request_line));
    rd(ADDR_RB, r);
    wr(ADDR_CON, 16'h8018);
    wr(ADDR_TB, xs());
    frame(xs(), 9, 250, 0, r);
    rdchk(ADDR_CON, exp_con(4'h8, 6'h18), "rate");
    chk("err rate", 16'h0001, 16'(error_request_line));
    wr(ADDR_CON, 16'h0000);
    rdchk(ADDR_BR, 16'h0007, "br kept");
    wr(ADDR_CON, 16'h802f);
    rdchk(ADDR_BR, 16'h0006, "br live");
    w = xs();
    p = xs();
    i_partner.arm(p);
    c = rx_cnt;
    wr(ADDR_TB, w);
    for (int n = 0; n < 600 && rx_cnt == c; n++)
    begin
      @(posedge core_clk);
      #1;
    end
    repeat (20) @(posedge core_clk);
    chk("master rx", 16'(c + 1), 16'(rx_cnt));
    chk("master tx", w, i_partner.s_rx);
    rdchk(ADDR_RB, p, "master rb");
    rdchk(ADDR_CON, exp_con(4'h0, 6'h2f), "master con");
    print_verdict();
  end
endmodule
